// file: hdl/ctu_consts.vh
`ifndef CTU_CONSTS_VH
`define CTU_CONSTS_VH

// ----------------------------------------------------------------
// register indices (byte-wide bus)
// ----------------------------------------------------------------
`define CTU_AW 3
`define CTU_DW 8
`define CTU_ADR_CTRL0 3'h0
`define CTU_ADR_CTRL1 3'h1
`define CTU_ADR_CNT_LO 3'h2
`define CTU_ADR_CNT_HI 3'h3
`define CTU_ADR_CMPA_LO 3'h4
`define CTU_ADR_CMPA_HI 3'h5
`define CTU_ADR_FLAGS 3'h6

// ----------------------------------------------------------------
// timer_control_0 fields
// ----------------------------------------------------------------
`define CTU_C0_PAUSE 7
`define CTU_C0_CKSEL_HI 6
`define CTU_C0_CKSEL_LO 4
`define CTU_C0_ENABLE 3
`define CTU_C0_PER_HI 2
`define CTU_C0_PER_LO 0

// ----------------------------------------------------------------
// timer_control_1 fields
// ----------------------------------------------------------------
`define CTU_C1_MODE_HI 7
`define CTU_C1_MODE_LO 6
`define CTU_C1_ACT_HI 5
`define CTU_C1_ACT_LO 4
`define CTU_C1_OCTL 3
`define CTU_C1_INV 2
`define CTU_C1_SWAP 1
`define CTU_C1_CLRSEL 0

// ----------------------------------------------------------------
// flags register bits (write one to clear)
// ----------------------------------------------------------------
`define CTU_FL_A 0
`define CTU_FL_P 1
`define CTU_NFLAG 2

// ----------------------------------------------------------------
// encodings and widths
// ----------------------------------------------------------------
`define CTU_MODE_CMP 2'h0
`define CTU_MODE_PWM 2'h2
`define CTU_MODE_TMR 2'h3
`define CTU_ACT_NONE 2'h0
`define CTU_ACT_LOW 2'h1
`define CTU_ACT_HIGH 2'h2
`define CTU_ACT_TOG 2'h3
`define CTU_PWM_INACT 2'h0
`define CTU_PWM_ACT 2'h1
`define CTU_PWM_WAVE 2'h2
`define CTU_CK_SYS4 3'h0
`define CTU_CK_SYS 3'h1
`define CTU_CK_H16 3'h2
`define CTU_CK_H64 3'h3
`define CTU_CK_SUB0 3'h4
`define CTU_CK_SUB1 3'h5
`define CTU_CK_EXTR 3'h6
`define CTU_CK_EXTF 3'h7
`define CTU_CW 10
`define CTU_PW 3
`define CTU_PSHIFT 7
`define CTU_FULL 11'h400
`define CTU_SUB_DIV 6103
`define CTU_SUBW 13

`endif

// file: hdl/ctu_timer.v
`include "ctu_consts.vh"

module ctu_timer #(
   parameter SUB_DIV = `CTU_SUB_DIV
) (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [`CTU_AW-1:0] wb_adr_i,
   input wire wb_sel_i,
   input wire [`CTU_DW-1:0] wb_dat_i,
   output reg [`CTU_DW-1:0] wb_dat_o,
   output reg wb_ack_o,
   // external count clock pin
   input wire ext_clk_i,
   // output pin
   output reg timer_pin_o,
   output reg timer_pin_oe_o,
   // match events
   output wire compare_a_flag_o,
   output wire period_match_flag_o
);

   // ----------------------------------------------------------------
   // bus decode helper
   // ----------------------------------------------------------------
   function wr_hit;
      input [`CTU_AW-1:0] adr;
      input [`CTU_AW-1:0] idx;
      input strobe;
      begin
         wr_hit = strobe & (adr == idx);
      end
   endfunction

   // ----------------------------------------------------------------
   // mode decode helper
   // ----------------------------------------------------------------
   function mode_is;
      input [1:0] m;
      input [1:0] code;
      begin
         mode_is = (m == code);
      end
   endfunction

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   reg [`CTU_DW-1:0] ctrl0_reg;
   reg [`CTU_DW-1:0] ctrl1_reg;
   reg [`CTU_CW-1:0] cmpa_reg;
   reg [`CTU_CW-1:0] cnt_reg;
   reg [`CTU_CW-1:0] cnt_next;
   reg en_prev_reg;
   reg pin_reg;
   reg pin_next;
   reg [`CTU_DW-1:0] rd_next;

   wire wr_stb;
   wire rd_stb;
   wire [1:0] mode;
   wire [1:0] action;
   wire [`CTU_PW-1:0] period;
   wire [2:0] cksel;
   wire enable;
   wire pause;
   wire octl;
   wire inv;
   wire swap;
   wire clrsel;

   // a write lands on the edge at which the master sees ack
   assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i & wb_ack_o;
   assign rd_stb = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
   assign mode = ctrl1_reg[`CTU_C1_MODE_HI:`CTU_C1_MODE_LO];
   assign action = ctrl1_reg[`CTU_C1_ACT_HI:`CTU_C1_ACT_LO];
   assign octl = ctrl1_reg[`CTU_C1_OCTL];
   assign inv = ctrl1_reg[`CTU_C1_INV];
   assign swap = ctrl1_reg[`CTU_C1_SWAP];
   assign clrsel = ctrl1_reg[`CTU_C1_CLRSEL];
   assign period = ctrl0_reg[`CTU_C0_PER_HI:`CTU_C0_PER_LO];
   assign cksel = ctrl0_reg[`CTU_C0_CKSEL_HI:`CTU_C0_CKSEL_LO];
   assign enable = ctrl0_reg[`CTU_C0_ENABLE];
   assign pause = ctrl0_reg[`CTU_C0_PAUSE];

   // ----------------------------------------------------------------
   // count clock sources
   // ----------------------------------------------------------------
   // the high-speed and system clocks both map onto clk_i here
   // the sub divider stands in for the slow oscillator; its rate is a parameter
   reg [5:0] pre_reg;
   reg [`CTU_SUBW-1:0] sub_reg;
   reg sub_tick;
   reg [2:0] ext_sync_reg;
   reg ext_old_reg;
   reg tick;
   wire ext_stable;

   always @(posedge clk_i) begin
      if (rst_i) begin
         pre_reg <= 6'h00;
         sub_reg <= {`CTU_SUBW{1'b0}};
         sub_tick <= 1'b0;
      end else begin
         pre_reg <= pre_reg + 6'h01;
         sub_tick <= 1'b0;
         if (sub_reg == SUB_DIV[`CTU_SUBW-1:0] - 1'b1) begin
            sub_reg <= {`CTU_SUBW{1'b0}};
            sub_tick <= 1'b1;
         end else begin
            sub_reg <= sub_reg + 1'b1;
         end
      end
   end

   // three stages; the first stage feeds only the second
   always @(posedge clk_i) begin
      if (rst_i) begin
         ext_sync_reg <= 3'h0;
         ext_old_reg <= 1'b0;
      end else begin
         ext_sync_reg <= {ext_sync_reg[1:0], ext_clk_i};
         if (ext_stable) begin
            ext_old_reg <= ext_sync_reg[2];
         end
      end
   end

   assign ext_stable = (ext_sync_reg[1] == ext_sync_reg[2]);

   always @* begin
      case (cksel)
         `CTU_CK_SYS4: tick = (pre_reg[1:0] == 2'h3);
         `CTU_CK_SYS: tick = 1'b1;
         `CTU_CK_H16: tick = (pre_reg[3:0] == 4'hF);
         `CTU_CK_H64: tick = (pre_reg == 6'h3F);
         `CTU_CK_SUB0: tick = sub_tick;
         `CTU_CK_SUB1: tick = sub_tick;
         `CTU_CK_EXTR: tick = ext_stable & ext_sync_reg[2] & ~ext_old_reg;
         `CTU_CK_EXTF: tick = ext_stable & ~ext_sync_reg[2] & ext_old_reg;
         default: tick = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // comparators
   // ----------------------------------------------------------------
   // matches look at the next count so a cleared period is exact
   wire [`CTU_CW:0] cnt_inc;
   wire [`CTU_CW:0] p_target;
   wire [`CTU_CW:0] a_target;
   wire a_hit;
   wire p_hit;
   wire run;
   wire en_rise;
   wire is_pwm;

   assign cnt_inc = {1'b0, cnt_reg} + 1'b1;
   assign a_target = {1'b0, cmpa_reg};
   // period value lines up with counter bits 9..7
   assign p_target = (period == {`CTU_PW{1'b0}}) ? `CTU_FULL :
                     {1'b0, period, {`CTU_PSHIFT{1'b0}}};
   // zero compare-A never matches, the counter simply wraps
   assign a_hit = (cmpa_reg != {`CTU_CW{1'b0}}) & (cnt_inc == a_target);
   assign p_hit = (cnt_inc == p_target);
   assign run = enable & ~pause & tick;
   assign en_rise = enable & ~en_prev_reg;
   assign is_pwm = mode_is(mode, `CTU_MODE_PWM);

   // ----------------------------------------------------------------
   // counter
   // ----------------------------------------------------------------
   reg clr_now;
   reg set_a;
   reg set_p;

   always @* begin
      clr_now = 1'b0;
      set_a = 1'b0;
      set_p = 1'b0;
      if (is_pwm) begin
         // clear select has no say in pwm
         clr_now = swap ? a_hit : p_hit;
         set_a = a_hit;
         set_p = p_hit;
      end else if (clrsel) begin
         clr_now = a_hit;
         set_a = a_hit;
      end else begin
         clr_now = p_hit;
         set_a = a_hit;
         set_p = p_hit;
      end
      set_a = set_a & run;
      set_p = set_p & run;
   end

   // pause and disable both hold the count; an enable rise or a clearing match zeroes it
   always @* begin
      cnt_next = cnt_reg;
      if (en_rise) begin
         cnt_next = {`CTU_CW{1'b0}};
      end else if (run) begin
         if (clr_now) begin
            cnt_next = {`CTU_CW{1'b0}};
         end else begin
            // 3FF rolls to zero through the dropped carry
            cnt_next = cnt_inc[`CTU_CW-1:0];
         end
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         cnt_reg <= {`CTU_CW{1'b0}};
         en_prev_reg <= 1'b0;
      end else begin
         // disabled: count is held, not cleared
         cnt_reg <= cnt_next;
         en_prev_reg <= enable;
      end
   end

   // ----------------------------------------------------------------
   // match flags (write one to clear)
   // ----------------------------------------------------------------
   wire clr_hit;
   wire [`CTU_NFLAG-1:0] flag_set;
   wire [`CTU_NFLAG-1:0] flag_q;
   genvar fi;

   assign clr_hit = wr_hit(wb_adr_i, `CTU_ADR_FLAGS, wr_stb);
   assign flag_set[`CTU_FL_A] = set_a;
   assign flag_set[`CTU_FL_P] = set_p;

   // each flag has its own cell; write data bit fi clears flag fi
   generate
      for (fi = 0; fi < `CTU_NFLAG; fi = fi + 1) begin : g_flag
         reg flag_reg;
         always @(posedge clk_i) begin
            if (rst_i) begin
               flag_reg <= 1'b0;
            end else begin
               // a new match beats a clear in the same cycle
               flag_reg <= (flag_reg & ~(clr_hit & wb_dat_i[fi])) | flag_set[fi];
            end
         end
         assign flag_q[fi] = flag_reg;
      end
   endgenerate

   assign compare_a_flag_o = flag_q[`CTU_FL_A];
   assign period_match_flag_o = flag_q[`CTU_FL_P];

   // ----------------------------------------------------------------
   // output pin
   // ----------------------------------------------------------------
   wire [`CTU_CW:0] duty;
   wire pwm_on;
   reg pwm_level;

   assign duty = swap ? p_target : a_target;
   // duty at or past the period keeps the compare true all period
   assign pwm_on = ({1'b0, cnt_reg} < duty);

   always @* begin
      pin_next = pin_reg;
      if (en_rise) begin
         pin_next = octl;
      end else if (set_a & mode_is(mode, `CTU_MODE_CMP)) begin
         // period matches never reach this branch
         case (action)
            `CTU_ACT_NONE: pin_next = pin_reg;
            `CTU_ACT_LOW: pin_next = 1'b0;
            `CTU_ACT_HIGH: pin_next = 1'b1;
            `CTU_ACT_TOG: pin_next = ~pin_reg;
            default: pin_next = pin_reg;
         endcase
      end
   end

   always @* begin
      // counting goes on underneath a forced level
      // changing the action while running glitches the pin; stop the timer first
      case (action)
         `CTU_PWM_INACT: pwm_level = ~octl;
         `CTU_PWM_ACT: pwm_level = octl;
         `CTU_PWM_WAVE: pwm_level = pwm_on ? octl : ~octl;
         default: pwm_level = ~octl;
      endcase
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         pin_reg <= 1'b0;
         timer_pin_o <= 1'b0;
         timer_pin_oe_o <= 1'b0;
      end else begin
         pin_reg <= pin_next;
         // timer/counter mode frees the pin for other use
         timer_pin_oe_o <= mode_is(mode, `CTU_MODE_CMP) | is_pwm;
         if (is_pwm) begin
            timer_pin_o <= pwm_level ^ inv;
         end else begin
            timer_pin_o <= pin_next ^ inv;
         end
      end
   end

   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         ctrl0_reg <= 8'h00;
         ctrl1_reg <= 8'h00;
         cmpa_reg <= {`CTU_CW{1'b0}};
      end else begin
         // counter bytes take no writes; the count is read-only
         if (wr_hit(wb_adr_i, `CTU_ADR_CTRL0, wr_stb)) begin
            ctrl0_reg <= wb_dat_i;
         end
         if (wr_hit(wb_adr_i, `CTU_ADR_CTRL1, wr_stb)) begin
            ctrl1_reg <= wb_dat_i;
         end
         if (wr_hit(wb_adr_i, `CTU_ADR_CMPA_LO, wr_stb)) begin
            cmpa_reg[7:0] <= wb_dat_i;
         end
         if (wr_hit(wb_adr_i, `CTU_ADR_CMPA_HI, wr_stb)) begin
            cmpa_reg[`CTU_CW-1:8] <= wb_dat_i[1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // register reads and ack
   // ----------------------------------------------------------------
   always @* begin
      case (wb_adr_i)
         `CTU_ADR_CTRL0: rd_next = ctrl0_reg;
         `CTU_ADR_CTRL1: rd_next = ctrl1_reg;
         `CTU_ADR_CNT_LO: rd_next = cnt_reg[7:0];
         `CTU_ADR_CNT_HI: rd_next = {6'h00, cnt_reg[`CTU_CW-1:8]};
         `CTU_ADR_CMPA_LO: rd_next = cmpa_reg[7:0];
         `CTU_ADR_CMPA_HI: rd_next = {6'h00, cmpa_reg[`CTU_CW-1:8]};
         `CTU_ADR_FLAGS: rd_next = {6'h00, flag_q};
         default: rd_next = 8'h00;
      endcase
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 8'h00;
      end else begin
         // one wait state, then ack for exactly one cycle
         // read data is caught with the ack so it stands while ack is high
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
         if (rd_stb) begin
            wb_dat_o <= rd_next;
         end
      end
   end

endmodule

// file: verification/ctu_timer_assertions.sv
module ctu_timer_assertions (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // register bus
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [2:0] wb_adr_i,
   input wire wb_sel_i,
   input wire [7:0] wb_dat_i,
   input wire [7:0] wb_dat_o,
   input wire wb_ack_o,
   // pins and events
   input wire ext_clk_i,
   input wire timer_pin_o,
   input wire timer_pin_oe_o,
   input wire compare_a_flag_o,
   input wire period_match_flag_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // ------
   // shadow of control 1 and recent writes
   // ------
   logic [7:0] c1;
   logic [2:0] wq;
   wire tk = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i;
   wire clr_a = tk && wb_adr_i == 3'h6 && wb_dat_i[0];
   wire clr_p = tk && wb_adr_i == 3'h6 && wb_dat_i[1];
   always @(posedge clk_i) begin
      if (rst_i) begin
         c1 <= 8'h00;
         wq <= 3'h0;
      end else begin
         wq <= {wq[1:0], tk};
         if (tk && wb_adr_i == 3'h1) begin
            c1 <= wb_dat_i;
         end
      end
   end

   sequence s_clr_on_a;
      (c1[0] && c1[7:6] != 2'h2) [*2];
   endsequence
   sequence s_cmp_quiet;
      c1[7:6] == 2'h0 && wq == 3'h0 && !$past(compare_a_flag_o);
   endsequence

   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held past one cycle");
   a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   a_unmapped_zero: assert property (
      wb_ack_o && !wb_we_i && wb_adr_i == 3'h7 |-> wb_dat_o == 8'h00)
      else $error("unmapped read not zero");
   a_high_bits_zero: assert property (
      wb_ack_o && !wb_we_i && (wb_adr_i == 3'h3 || wb_adr_i == 3'h5) |-> wb_dat_o[7:2] == 6'h00)
      else $error("unused high bits not zero");
   a_flag_a_hold: assert property (compare_a_flag_o && !clr_a |=> compare_a_flag_o)
      else $error("compare flag lost without clear");
   a_flag_p_hold: assert property (period_match_flag_o && !clr_p |=> period_match_flag_o)
      else $error("period flag lost without clear");
   a_no_period_flag: assert property (
      s_clr_on_a ##0 !period_match_flag_o |=> !period_match_flag_o)
      else $error("period flag set while clearing on compare");
   a_timer_no_drive: assert property ((c1[7:6] == 2'h3) [*2] |-> !timer_pin_oe_o)
      else $error("pin driven in timer mode");
   a_pin_on_match: assert property (
      s_cmp_quiet ##0 $changed(timer_pin_o) |-> $rose(compare_a_flag_o))
      else $error("pin moved without compare match");
endmodule

bind ctu_timer ctu_timer_assertions u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_clk_i(ext_clk_i),
   .timer_pin_o(timer_pin_o), .timer_pin_oe_o(timer_pin_oe_o),
   .compare_a_flag_o(compare_a_flag_o), .period_match_flag_o(period_match_flag_o));

// file: verification/ctu_timer_test.sv
module ctu_timer_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic wb_sel_i = 1'b0;
   logic ext_clk_i = 1'b0;
   logic [2:0] wb_adr_i = 3'h0;
   logic [7:0] wb_dat_i = 8'h00;
   wire [7:0] wb_dat_o;
   wire wb_ack_o, timer_pin_o, timer_pin_oe_o, compare_a_flag_o, period_match_flag_o;
   int n_mismatch = 0;
   int num_checks = 0;
   int cyc_cnt = 0;
   int t0, t1;
   logic ext_run = 1'b0;
   logic [7:0] q;
   logic [7:0] mir [0:7];
   // pwm cases: swap, period value, compare-A (-1/-2 random), action, invert
   int sw[6] = '{0, 0, 0, 1, 0, 0};
   int pv[6] = '{1, 1, 1, 1, 2, 2};
   int ca[6] = '{-1, -1, 200, -2, 100, 100};
   int ac[6] = '{2, 2, 2, 2, 0, 1};
   int iv[6] = '{0, 1, 0, 0, 0, 0};
   // count clock selections and system cycles per tick (sub divider is 4 here)
   int ck[7] = '{1, 0, 6, 2, 4, 7, 3};
   int mul[7] = '{1, 4, 8, 16, 4, 8, 64};

   ctu_timer #(.SUB_DIV(4)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_clk_i(ext_clk_i),
      .timer_pin_o(timer_pin_o), .timer_pin_oe_o(timer_pin_oe_o),
      .compare_a_flag_o(compare_a_flag_o), .period_match_flag_o(period_match_flag_o));

   always #2.5 clk_i = ~clk_i;
   // external count clock: one rising edge every 8 cycles
   always @(posedge clk_i) begin
      cyc_cnt <= cyc_cnt + 1;
      if (ext_run && cyc_cnt % 4 == 0) begin
         ext_clk_i <= ~ext_clk_i;
      end
   end

   // ------
   // checking and bus tasks
   // ------
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic fail(input string m);
      n_mismatch++;
      $display("MISMATCH t=%0t %s", $time, m);
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
      num_checks++;
      if (got !== exp) fail($sformatf("%s got %h exp %h", m, got, exp));
   endtask
   task automatic chkn(input int got, input int exp, input string m);
      num_checks++;
      if (got != exp) fail($sformatf("%s got %0d exp %0d", m, got, exp));
   endtask
   task automatic bus(input logic [2:0] a, input logic [7:0] d, input logic w, input logic s);
      int i;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_sel_i <= s;
      wb_adr_i <= a;
      wb_dat_i <= d;
      i = 0;
      do begin
         @(posedge clk_i);
         i++;
      end while (wb_ack_o !== 1'b1 && i < 50);
      if (i >= 50) begin
         fail("bus timeout");
         stop_test();
      end
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (w && s && a inside {3'h0, 3'h1, 3'h4, 3'h5}) mir[a] = (a == 3'h5) ? d & 8'h03 : d;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      bus(a, d, 1'b1, 1'b1);
   endtask
   task automatic rdc(input logic [2:0] a);
      bus(a, 8'h00, 1'b0, 1'b1);
      chk8(q, mir[a], "register read");
   endtask
   task automatic seta(input int v);
      wr(3'h4, v[7:0]);
      wr(3'h5, {6'h00, v[9:8]});
   endtask
   // stop, clear flags, set mode, then enable
   task automatic run(input logic [7:0] c0, input logic [7:0] c1);
      wr(3'h0, 8'h00);
      wr(3'h6, 8'h03);
      wr(3'h1, c1);
      wr(3'h0, c0 | 8'h08);
   endtask
   task automatic wsig(input int k, input logic v, output int t);
      int i;
      logic s;
      for (i = 0; i < 20000; i++) begin
         @(posedge clk_i);
         s = (k == 0) ? compare_a_flag_o : (k == 1) ? period_match_flag_o : timer_pin_o;
         if (s === v) break;
      end
      if (i >= 20000) begin
         fail("wait timeout");
         stop_test();
      end
      t = cyc_cnt;
   endtask

   // ------
   // main sequence
   // ------
   initial begin
      int k, v, e, per, dut_n, act_n, hi;
      void'($urandom(32'h0EC18A30));
      for (k = 0; k < 8; k++) mir[k] = 8'h00;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      for (k = 0; k < 8; k++) rdc(k[2:0]);
      v = $urandom_range(1023, 0);
      wr(3'h4, v[7:0]);
      wr(3'h5, 8'hFC | v[9:8]);
      wr(3'h2, 8'hFF);
      wr(3'h3, 8'hFF);
      bus(3'h4, ~v[7:0], 1'b1, 1'b0);
      for (k = 2; k < 6; k++) rdc(k[2:0]);
      $display("test registers done");
      for (e = 0; e < 7; e++) begin
         k = ck[e];
         v = $urandom_range(200, 130);
         ext_run <= (k >= 6);
         seta(v);
         run(8'((k << 4) | 1), 8'h39);
         repeat (3) @(posedge clk_i);
         chk8({7'h00, timer_pin_o}, 8'h01, "initial level");
         wsig(2, 1'b0, t0);
         wsig(2, 1'b1, t1);
         chkn(t1 - t0, v * mul[e], "toggle interval");
         chk8({6'h00, period_match_flag_o, compare_a_flag_o}, 8'h01, "flags");
      end
      $display("test compare clear done");
      for (k = 0; k < 4; k++) begin
         e = $urandom_range(1, 0);
         seta(40);
         run(8'h11, 8'((k << 4) | (e << 3) | 1));
         wsig(0, 1'b1, t0);
         v = (k == 0) ? e : (k == 1) ? 0 : (k == 2) ? 1 : 1 - e;
         chk8({6'h00, timer_pin_oe_o, timer_pin_o}, 8'(2 | v), "pin action");
      end
      $display("test pin actions done");
      v = $urandom_range(3, 1);
      seta(50);
      run(8'(16 | v), 8'h00);
      wsig(1, 1'b1, t0);
      bus(3'h6, 8'h00, 1'b0, 1'b1);
      chk8(q, 8'h03, "both flags");
      wr(3'h6, 8'h03);
      wsig(1, 1'b1, t1);
      chkn(t1 - t0, v * 128, "period match");
      seta(0);
      run(8'h10, 8'h00);
      wsig(1, 1'b1, t0);
      wr(3'h6, 8'h03);
      wsig(1, 1'b1, t1);
      chkn(t1 - t0, 1024, "overflow");
      chk8({7'h00, compare_a_flag_o}, 8'h00, "no compare flag");
      wr(3'h0, 8'h10);
      for (k = 0; k < 2; k++) begin
         repeat (20) @(posedge clk_i);
         bus(3'h2, 8'h00, 1'b0, 1'b1);
         hi = q;
         bus(3'h3, 8'h00, 1'b0, 1'b1);
         hi = hi | (q << 8);
         if (k == 0) v = hi;
      end
      chkn(hi, v, "held count");
      seta(60);
      run(8'h11, 8'hF9);
      wsig(0, 1'b1, t0);
      wr(3'h6, 8'h03);
      wsig(0, 1'b1, t1);
      chkn(t1 - t0, 60, "timer interval");
      chk8({7'h00, timer_pin_oe_o}, 8'h00, "pin released");
      $display("test period and timer done");
      for (k = 0; k < 6; k++) begin
         v = (ca[k] == -1) ? $urandom_range(127, 1) : (ca[k] == -2) ? $urandom_range(250, 130) : ca[k];
         seta(v);
         run(8'(16 | pv[k]), 8'(8'h89 | (ac[k] << 4) | (iv[k] << 2) | (sw[k] << 1)));
         per = sw[k] ? v : pv[k] * 128;
         dut_n = sw[k] ? pv[k] * 128 : v;
         act_n = (ac[k] == 2) ? ((dut_n < per) ? dut_n : per) : (ac[k] == 1) ? per : 0;
         repeat (per + 4) @(posedge clk_i);
         hi = 0;
         repeat (per) begin
            @(posedge clk_i);
            hi += (timer_pin_o === 1'b1);
         end
         chkn(hi, iv[k] ? per - act_n : act_n, "pwm high time");
         bus(3'h6, 8'h00, 1'b0, 1'b1);
         chk8(q, 8'(2 | (sw[k] || v < per)), "pwm flags");
      end
      $display("test pwm done");
      stop_test();
   end
endmodule
